// file: umon_pkg.sv
package umon_pkg;

   // Register offsets within one security frame
   localparam logic [11:0] OFS_MONITOR_SELECTOR = 12'h800;
   localparam logic [11:0] OFS_OVERFLOW_BITMAP = 12'h858;
   localparam logic [11:0] OFS_BW_COUNTER = 12'h860;
   localparam logic [11:0] OFS_BW_SNAPSHOT = 12'h868;

   // Monitor selector field layout
   localparam int MON_INDEX_LSB = 0;
   localparam int MON_INDEX_W = 16;
   localparam int RES_SELECT_LSB = 24;
   localparam int RES_SELECT_W = 4;
   localparam logic [31:0] SELECTOR_WMASK = 32'h0f00_ffff;
   localparam logic [31:0] SELECTOR_RESET = 32'h0000_0000;

   // Overflow bitmap grouping
   localparam logic [15:0] GROUP_BASE_MASK = 16'hffe0;
   localparam int GROUP_SIZE = 32;

   // Counter and snapshot layout
   localparam int NOT_READY_BIT = 31;
   localparam int COUNT_W = 31;
   localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
   localparam logic [31:0] SNAPSHOT_RESET = 32'h0000_0000;
   localparam logic [31:0] ABSENT_READ = 32'h0000_0000;

   // Frame numbering: one register set per security state
   localparam int NUM_FRAMES = 2;
   localparam int FRAME_NONSECURE = 0;
   localparam int FRAME_SECURE = 1;

endpackage

// file: umon_bw_counter.sv
`timescale 1ns/100ps

// One bandwidth usage monitor with its snapshot
module umon_bw_counter
   import umon_pkg::*;
#(
   parameter int ACC_W = 48,
   parameter int BYTES_W = 16,
   parameter int SHIFT_W = 5
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic count_en_i,
   input wire logic [BYTES_W-1:0] bytes_i,
   input wire logic scale_en_i,
   input wire logic [SHIFT_W-1:0] shift_i,
   input wire logic not_ready_set_i,
   input wire logic wr_counter_i,
   input wire logic wr_snapshot_i,
   input wire logic [31:0] wdata_i,
   input wire logic capture_i,
   output logic [31:0] counter_o,
   output logic [31:0] snapshot_o
);

   logic [ACC_W-1:0] byte_total;
   logic not_ready;
   logic [31:0] snapshot;
   logic [ACC_W-1:0] round_add;
   logic [ACC_W-1:0] scaled;
   logic [SHIFT_W-1:0] eff_shift;

   // Scaled view with round-half-up
   always_comb begin
      eff_shift = scale_en_i ? shift_i : '0;
      round_add = '0;
      if (eff_shift != '0) begin
         round_add = ACC_W'(1) << (eff_shift - SHIFT_W'(1));
      end
      scaled = (byte_total + round_add) >> eff_shift;
   end

   assign counter_o = {not_ready, scaled[COUNT_W-1:0]};
   assign snapshot_o = snapshot;

   // Byte accumulator; a software write restarts it and beats a beat
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         byte_total <= '0;
      end else if (wr_counter_i) begin
         byte_total <= ACC_W'(wdata_i[COUNT_W-1:0]) << eff_shift;
      end else if (count_en_i) begin
         byte_total <= byte_total + ACC_W'(bytes_i);
      end
   end

   // Not-ready flag; a hardware set beats a software clear
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         not_ready <= COUNTER_RESET[NOT_READY_BIT];
      end else if (not_ready_set_i) begin
         not_ready <= 1'b1;
      end else if (wr_counter_i) begin
         not_ready <= wdata_i[NOT_READY_BIT];
      end
   end

   // Snapshot copies flag and scaled count in one edge
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         snapshot <= SNAPSHOT_RESET;
      end else if (capture_i) begin
         snapshot <= counter_o;
      end else if (wr_snapshot_i) begin
         snapshot <= wdata_i;
      end
   end

endmodule

// file: umon_ovf_bitmap.sv
`timescale 1ns/100ps

// Pending-overflow flags for one frame, read as groups of 32
module umon_ovf_bitmap
   import umon_pkg::*;
#(
   parameter int TOTAL = 64,
   parameter int IDX_W = 6
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic set_i,
   input wire logic [IDX_W-1:0] set_idx_i,
   input wire logic clr_i,
   input wire logic [IDX_W-1:0] clr_idx_i,
   input wire logic [31:0] base_i,
   output logic [GROUP_SIZE-1:0] bitmap_o
);

   logic [TOTAL-1:0] pending;

   // Wrap event wins over a clear in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < TOTAL; gi++) begin : g_flag
         always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               pending[gi] <= 1'b0;
            end else if (set_i && set_idx_i == IDX_W'(gi)) begin
               pending[gi] <= 1'b1;
            end else if (clr_i && clr_idx_i == IDX_W'(gi)) begin
               pending[gi] <= 1'b0;
            end
         end
      end
      // Bits past the last monitor read as zero
      for (gi = 0; gi < GROUP_SIZE; gi++) begin : g_view
         logic [31:0] pos;
         assign pos = base_i + 32'(gi);
         assign bitmap_o[gi] = (pos < 32'(TOTAL)) ? pending[pos[IDX_W-1:0]] : 1'b0;
      end
   endgenerate

endmodule

// file: umon_regs.sv
`timescale 1ns/100ps

// Function
// - A 32-bit read-only bitmap shows overflow pending for 32 storage monitors.
// - Bit i covers monitor (monitor_index AND 0xFFE0) plus i; 1 means pending.
// - Bitmap group and resource come from the current selector settings.
// - Without the bitmap option its location reads zero and ignores writes.
// - Bitmap sits at 0x0858 in both frames and is read-only.
// - Secure and non-secure frames each own separate register instances.
// - Counter accesses target the monitor chosen by resource and index.
// - Counter reads zero unless monitoring and bandwidth monitors are present.
// - Counter bit 31 is not-ready flag, bits 30..0 the count.
// - Count accumulates matching bytes since the monitor was last reset.
// - With scaling on, count is byte total shifted right and rounded.
// - Counter is read-write at 0x0860, snapshot at 0x0868, per frame.
// - Snapshot reads zero unless monitoring, bandwidth and snapshot all present.
// - Snapshot holds the captured flag in bit 31 and count below.
// - Captured count keeps the scaling applied when it was taken.
// - Snapshot accesses select the monitor by resource and index.
// - Each frame has a read-write selector at 0x0800 steering accesses.
module umon_regs
   import umon_pkg::*;
#(
   parameter bit HAS_MONITORING = 1'b1,
   parameter bit HAS_BW_MONITOR = 1'b1,
   parameter bit HAS_SNAPSHOT = 1'b1,
   parameter bit HAS_OVERFLOW_BITMAP = 1'b1,
   parameter bit HAS_RESOURCE_SELECT = 1'b1,
   parameter int NUM_RES = 2,
   parameter int NUM_BW_MON = 4,
   parameter int NUM_CSU_MON = 40,
   parameter int ACC_W = 48,
   parameter int BYTES_W = 16,
   parameter int SHIFT_W = 5,
   localparam int BW_TOTAL = (HAS_RESOURCE_SELECT ? NUM_RES : 1) * NUM_BW_MON,
   localparam int CSU_TOTAL = (HAS_RESOURCE_SELECT ? NUM_RES : 1) * NUM_CSU_MON,
   localparam int BW_IDX_W = (BW_TOTAL > 1) ? $clog2(BW_TOTAL) : 1,
   localparam int CSU_IDX_W = (CSU_TOTAL > 1) ? $clog2(CSU_TOTAL) : 1
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic reg_req_i,
   input wire logic reg_wr_i,
   input wire logic reg_secure_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_ack_o,
   input wire logic bw_valid_i,
   input wire logic bw_secure_i,
   input wire logic [BW_IDX_W-1:0] bw_idx_i,
   input wire logic [BYTES_W-1:0] bw_bytes_i,
   input wire logic [NUM_FRAMES-1:0] scale_en_i,
   input wire logic [SHIFT_W-1:0] shift_amount_i,
   input wire logic [NUM_FRAMES-1:0] not_ready_set_i,
   input wire logic [NUM_FRAMES-1:0] capture_i,
   input wire logic csu_wrap_i,
   input wire logic csu_wrap_secure_i,
   input wire logic [CSU_IDX_W-1:0] csu_wrap_idx_i,
   input wire logic csu_clr_i,
   input wire logic csu_clr_secure_i,
   input wire logic [CSU_IDX_W-1:0] csu_clr_idx_i,
   output logic [31:0] selector_ns_o,
   output logic [31:0] selector_s_o
);

   ////////////////////////////////////////////////////////////////////////
   // Presence and access decode

   localparam bit BW_PRESENT = HAS_MONITORING && HAS_BW_MONITOR;
   localparam bit SNAP_PRESENT = BW_PRESENT && HAS_SNAPSHOT;

   logic hit_selector;
   logic hit_bitmap;
   logic hit_counter;
   logic hit_snapshot;
   logic wr_access;
   logic [NUM_FRAMES-1:0] frame_hit;

   // Offsets are the same in both frames
   assign hit_selector = reg_addr_i == OFS_MONITOR_SELECTOR;
   assign hit_bitmap = reg_addr_i == OFS_OVERFLOW_BITMAP;
   assign hit_counter = reg_addr_i == OFS_BW_COUNTER;
   assign hit_snapshot = reg_addr_i == OFS_BW_SNAPSHOT;
   assign wr_access = reg_req_i && reg_wr_i;

   // Each access reaches only the frame it came in on
   assign frame_hit[FRAME_NONSECURE] = !reg_secure_i;
   assign frame_hit[FRAME_SECURE] = reg_secure_i;

   ////////////////////////////////////////////////////////////////////////
   // Per-frame selectors, monitors and bitmaps

   logic [31:0] selector [NUM_FRAMES];
   logic [31:0] sel_flat [NUM_FRAMES];
   logic [31:0] group_base [NUM_FRAMES];
   logic sel_in_range [NUM_FRAMES];
   logic [31:0] live_word [NUM_FRAMES];
   logic [31:0] snap_word [NUM_FRAMES];
   logic [GROUP_SIZE-1:0] bitmap_word [NUM_FRAMES];

   genvar gf;
   genvar gm;
   generate
      for (gf = 0; gf < NUM_FRAMES; gf++) begin : g_frame
         logic [MON_INDEX_W-1:0] mon_index;
         logic [RES_SELECT_W-1:0] res_select;
         logic [31:0] res_eff;
         logic [31:0] counter_rd [BW_TOTAL];
         logic [31:0] snapshot_rd [BW_TOTAL];
         logic wr_sel_frame;
         logic wr_cnt_frame;
         logic wr_snap_frame;
         logic [BW_IDX_W-1:0] sel_idx;

         assign mon_index = selector[gf][MON_INDEX_LSB +: MON_INDEX_W];
         assign res_select = selector[gf][RES_SELECT_LSB +: RES_SELECT_W];
         // Resource field is ignored when resource selection is absent
         assign res_eff = HAS_RESOURCE_SELECT ? 32'(res_select) : 32'h0000_0000;

         // Flat monitor number: resource and index, or index alone
         assign sel_flat[gf] = res_eff * 32'(NUM_BW_MON) + 32'(mon_index);
         assign sel_in_range[gf] = (32'(mon_index) < 32'(NUM_BW_MON))
            && (res_eff < 32'(HAS_RESOURCE_SELECT ? NUM_RES : 1));
         assign sel_idx = sel_flat[gf][BW_IDX_W-1:0];

         // Bitmap group starts at the index rounded down to 32
         assign group_base[gf] = res_eff * 32'(NUM_CSU_MON)
            + 32'(mon_index & GROUP_BASE_MASK);

         assign wr_sel_frame = wr_access && frame_hit[gf] && hit_selector;
         assign wr_cnt_frame = wr_access && frame_hit[gf] && hit_counter
            && BW_PRESENT && sel_in_range[gf];
         assign wr_snap_frame = wr_access && frame_hit[gf] && hit_snapshot
            && SNAP_PRESENT && sel_in_range[gf];

         // Selector holds only its defined fields
         always_ff @(posedge mclk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               selector[gf] <= SELECTOR_RESET;
            end else if (wr_sel_frame) begin
               selector[gf] <= reg_wdata_i & SELECTOR_WMASK;
            end
         end

         for (gm = 0; gm < BW_TOTAL; gm++) begin : g_mon
            logic count_hit;
            logic wr_cnt_mon;
            logic wr_snap_mon;
            logic capture_mon;

            // Traffic counts only in the frame of its security state
            assign count_hit = bw_valid_i && (bw_secure_i == (gf == FRAME_SECURE))
               && bw_idx_i == BW_IDX_W'(gm);
            assign wr_cnt_mon = wr_cnt_frame && sel_idx == BW_IDX_W'(gm);
            assign wr_snap_mon = wr_snap_frame && sel_idx == BW_IDX_W'(gm);
            // Capture takes the monitor the frame selector points at
            assign capture_mon = capture_i[gf] && SNAP_PRESENT && sel_in_range[gf]
               && sel_idx == BW_IDX_W'(gm);

            umon_bw_counter #(
               .ACC_W(ACC_W),
               .BYTES_W(BYTES_W),
               .SHIFT_W(SHIFT_W)
            ) u_counter (
               .mclk_i(mclk_i),
               .nrst_i(nrst_i),
               .count_en_i(count_hit),
               .bytes_i(bw_bytes_i),
               .scale_en_i(scale_en_i[gf]),
               .shift_i(shift_amount_i),
               .not_ready_set_i(not_ready_set_i[gf]),
               .wr_counter_i(wr_cnt_mon),
               .wr_snapshot_i(wr_snap_mon),
               .wdata_i(reg_wdata_i),
               .capture_i(capture_mon),
               .counter_o(counter_rd[gm]),
               .snapshot_o(snapshot_rd[gm])
            );
         end

         // Selected monitor words; out-of-range selection reads zero
         assign live_word[gf] = sel_in_range[gf] ? counter_rd[sel_idx] : ABSENT_READ;
         assign snap_word[gf] = sel_in_range[gf] ? snapshot_rd[sel_idx] : ABSENT_READ;

         logic [GROUP_SIZE-1:0] raw_bitmap;
         logic [GROUP_SIZE-1:0] in_res;

         // A group can run past its resource's last monitor; never show the next resource
         for (genvar gb = 0; gb < GROUP_SIZE; gb++) begin : g_bit
            assign in_res[gb] = (32'(mon_index & GROUP_BASE_MASK) + 32'(gb)
               < 32'(NUM_CSU_MON)) && (res_eff < 32'(HAS_RESOURCE_SELECT ? NUM_RES : 1));
         end
         assign bitmap_word[gf] = raw_bitmap & in_res;

         umon_ovf_bitmap #(
            .TOTAL(CSU_TOTAL),
            .IDX_W(CSU_IDX_W)
         ) u_bitmap (
            .mclk_i(mclk_i),
            .nrst_i(nrst_i),
            .set_i(csu_wrap_i && (csu_wrap_secure_i == (gf == FRAME_SECURE))),
            .set_idx_i(csu_wrap_idx_i),
            .clr_i(csu_clr_i && (csu_clr_secure_i == (gf == FRAME_SECURE))),
            .clr_idx_i(csu_clr_idx_i),
            .base_i(group_base[gf]),
            .bitmap_o(raw_bitmap)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read data selection

   logic [31:0] next_rdata;
   logic frame_sel;

   assign frame_sel = reg_secure_i;

   // Absent registers read zero; bitmap write is silently dropped
   always_comb begin
      next_rdata = ABSENT_READ;
      if (hit_selector) begin
         next_rdata = selector[frame_sel];
      end else if (hit_bitmap && HAS_OVERFLOW_BITMAP) begin
         next_rdata = 32'(bitmap_word[frame_sel]);
      end else if (hit_counter && BW_PRESENT) begin
         next_rdata = live_word[frame_sel];
      end else if (hit_snapshot && SNAP_PRESENT) begin
         next_rdata = snap_word[frame_sel];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer registers

   // Every access, mapped or not, is answered on the next edge
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_ack_o <= 1'b0;
      end else begin
         reg_ack_o <= reg_req_i;
      end
   end

   // Read data held until the next access; writes return zero
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_req_i) begin
         reg_rdata_o <= reg_wr_i ? 32'h0000_0000 : next_rdata;
      end
   end

   // Selector copies for the storage-monitor logic outside
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         selector_ns_o <= SELECTOR_RESET;
         selector_s_o <= SELECTOR_RESET;
      end else begin
         selector_ns_o <= selector[FRAME_NONSECURE];
         selector_s_o <= selector[FRAME_SECURE];
      end
   end

endmodule

// file: umon_regs_asserts.sv
`timescale 1ns/100ps
// Register port and selector checks, seen from the top ports only
module umon_regs_asserts
   import umon_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic reg_req_i,
   input wire logic reg_wr_i,
   input wire logic reg_secure_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic reg_ack_o,
   input wire logic [31:0] selector_ns_o,
   input wire logic [31:0] selector_s_o
);
   logic [31:0] sel_ns;
   logic [31:0] sel_s;
   logic sel_wr;
   logic known;
   logic rd_req;
   ////////////////////////////////////////////////////////////////////////////////
   // Decode of the current request
   assign sel_wr = reg_req_i && reg_wr_i && reg_addr_i == OFS_MONITOR_SELECTOR;
   assign rd_req = reg_req_i && !reg_wr_i;
   assign known = reg_addr_i inside {OFS_MONITOR_SELECTOR, OFS_OVERFLOW_BITMAP,
      OFS_BW_COUNTER, OFS_BW_SNAPSHOT};
   // Shadow selectors, kept apart so a crossed frame shows up
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sel_ns <= SELECTOR_RESET;
         sel_s <= SELECTOR_RESET;
      end else if (sel_wr && reg_secure_i) begin
         sel_s <= reg_wdata_i & SELECTOR_WMASK;
      end else if (sel_wr) begin
         sel_ns <= reg_wdata_i & SELECTOR_WMASK;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   AST_ACK_NEXT: assert property (reg_req_i |=> reg_ack_o)
      else $error("no ack after request");
   AST_ACK_CAUSE: assert property (reg_ack_o |-> $past(reg_req_i))
      else $error("ack without request");
   AST_WRITE_ZERO: assert property (reg_req_i && reg_wr_i |=> reg_rdata_o == ABSENT_READ)
      else $error("read data not zero after write");
   AST_RDATA_HOLD: assert property (!reg_req_i |=> $stable(reg_rdata_o))
      else $error("read data moved without request");
   AST_HOLE_ZERO: assert property (rd_req && !known |=> reg_rdata_o == ABSENT_READ)
      else $error("unmapped read not zero");
   AST_SEL_NS: assert property (selector_ns_o == $past(sel_ns))
      else $error("non-secure selector wrong");
   AST_SEL_S: assert property (selector_s_o == $past(sel_s))
      else $error("secure selector wrong");
   AST_SEL_RD_NS: assert property (rd_req && sel_wr == 1'b0
      && reg_addr_i == OFS_MONITOR_SELECTOR && !reg_secure_i
      |=> reg_rdata_o == $past(sel_ns))
      else $error("non-secure selector read wrong");
   AST_SEL_RD_S: assert property (rd_req && reg_addr_i == OFS_MONITOR_SELECTOR
      && reg_secure_i |=> reg_rdata_o == $past(sel_s))
      else $error("secure selector read wrong");
   // Main traffic seen at least once
   cover property (sel_wr && reg_secure_i);
   cover property (rd_req && reg_addr_i == OFS_BW_SNAPSHOT);
   cover property (rd_req && reg_addr_i == OFS_OVERFLOW_BITMAP);
endmodule

bind umon_regs umon_regs_asserts umon_regs_asserts_i (.mclk_i(mclk_i), .nrst_i(nrst_i),
   .reg_req_i(reg_req_i), .reg_wr_i(reg_wr_i), .reg_secure_i(reg_secure_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .reg_ack_o(reg_ack_o), .selector_ns_o(selector_ns_o), .selector_s_o(selector_s_o));

// file: usage_monitor_registers_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the usage monitor register bank
module usage_monitor_registers_tb
   import umon_pkg::*;
;
   logic mclk_i, nrst_i, reg_req_i, reg_wr_i, reg_secure_i, reg_ack_o;
   logic bw_valid_i, bw_secure_i, csu_wrap_i, csu_wrap_secure_i, csu_clr_i, csu_clr_secure_i;
   logic [11:0] reg_addr_i;
   logic [31:0] reg_wdata_i, reg_rdata_o, d;
   logic [2:0] bw_idx_i;
   logic [15:0] bw_bytes_i;
   logic [1:0] scale_en_i, not_ready_set_i, capture_i;
   logic [4:0] shift_amount_i;
   logic [6:0] csu_wrap_idx_i, csu_clr_idx_i;
   logic [11:0] ofs[5] = '{OFS_MONITOR_SELECTOR, OFS_OVERFLOW_BITMAP, OFS_BW_COUNTER,
      OFS_BW_SNAPSHOT, 12'h804};
   longint tot[2][8];
   logic not_ready_flag[2][8];
   logic [31:0] snap[2][8];
   bit pend[2][80];
   int fail_count, samples_checked, cyc, f, m, k;

   umon_regs umon_regs_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_req_i(reg_req_i),
      .reg_wr_i(reg_wr_i), .reg_secure_i(reg_secure_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
      .bw_valid_i(bw_valid_i), .bw_secure_i(bw_secure_i), .bw_idx_i(bw_idx_i),
      .bw_bytes_i(bw_bytes_i), .scale_en_i(scale_en_i), .shift_amount_i(shift_amount_i),
      .not_ready_set_i(not_ready_set_i), .capture_i(capture_i), .csu_wrap_i(csu_wrap_i),
      .csu_wrap_secure_i(csu_wrap_secure_i), .csu_wrap_idx_i(csu_wrap_idx_i),
      .csu_clr_i(csu_clr_i), .csu_clr_secure_i(csu_clr_secure_i),
      .csu_clr_idx_i(csu_clr_idx_i), .selector_ns_o(), .selector_s_o());
   ////////////////////////////////////////////////////////////////////////////////
   // 50 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   // Hang guard, well above the roughly 500 cycles the run needs
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Counter as software sees it: rounded half up when scaled
   function automatic logic [31:0] cval(input int fr, input int mi);
      longint t;
      t = tot[fr][mi];
      if (scale_en_i[fr] && shift_amount_i != 5'h0) begin
         t = (t + (longint'(1) << (shift_amount_i - 5'h1))) >> shift_amount_i;
      end
      return {not_ready_flag[fr][mi], t[30:0]};
   endfunction
   // Pending group for one resource; places past the last monitor read zero
   function automatic logic [31:0] bm(input int fr, input int r, input int mon);
      logic [31:0] e;
      int j;
      e = '0;
      for (int i = 0; i < 32; i++) begin
         j = int'(16'(mon) & GROUP_BASE_MASK) + i;
         if (j < 40) e[i] = pend[fr][r * 40 + j];
      end
      return e;
   endfunction
   // One register access; request held a single cycle, answer sampled after ack edge
   task automatic acc(input bit w, input int s, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] r);
      @(posedge mclk_i);
      reg_req_i <= 1'b1;
      reg_wr_i <= w;
      reg_secure_i <= s[0];
      reg_addr_i <= a;
      reg_wdata_i <= wd;
      @(posedge mclk_i);
      reg_req_i <= 1'b0;
      #1;
      chk({31'h0, reg_ack_o}, 32'h1);
      r = reg_rdata_o;
   endtask
   task automatic rd(input int s, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      acc(1'b0, s, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic wr(input int s, input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] r;
      acc(1'b1, s, a, wd, r);
   endtask
   task automatic pick(input int fr, input int r, input int mon);
      wr(fr, OFS_MONITOR_SELECTOR, {4'h0, 4'(r), 8'h0, 16'(mon)});
   endtask
   task automatic cwr(input int fr, input int mi, input logic [31:0] v);
      wr(fr, OFS_BW_COUNTER, v);
      tot[fr][mi] = scale_en_i[fr] ? longint'(v[30:0]) << shift_amount_i : longint'(v[30:0]);
      not_ready_flag[fr][mi] = v[31];
   endtask
   // Back-to-back traffic beats
   task automatic beats(input int fr, input int mi, input int n);
      logic [15:0] b;
      repeat (n) begin
         @(posedge mclk_i);
         b = 16'($urandom);
         bw_valid_i <= 1'b1;
         bw_secure_i <= fr[0];
         bw_idx_i <= 3'(mi);
         bw_bytes_i <= b;
         tot[fr][mi] += b;
      end
      @(posedge mclk_i);
      bw_valid_i <= 1'b0;
   endtask
   task automatic cap(input int fr, input int mi);
      @(posedge mclk_i);
      capture_i[fr] <= 1'b1;
      snap[fr][mi] = cval(fr, mi);
      @(posedge mclk_i);
      capture_i <= 2'b00;
   endtask
   task automatic csu(input bit set, input int fr, input int j);
      @(posedge mclk_i);
      csu_wrap_i <= set;
      csu_clr_i <= !set;
      csu_wrap_secure_i <= fr[0];
      csu_clr_secure_i <= fr[0];
      csu_wrap_idx_i <= 7'(j);
      csu_clr_idx_i <= 7'(j);
      pend[fr][j] = set;
      @(posedge mclk_i);
      csu_wrap_i <= 1'b0;
      csu_clr_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      nrst_i = 1'b0;
      {reg_req_i, reg_wr_i, reg_secure_i, reg_addr_i, reg_wdata_i, bw_valid_i, bw_secure_i,
         bw_idx_i, bw_bytes_i, scale_en_i, shift_amount_i, not_ready_set_i, capture_i} = '0;
      {csu_wrap_i, csu_wrap_secure_i, csu_wrap_idx_i, csu_clr_i, csu_clr_secure_i,
         csu_clr_idx_i} = '0;
      d = $urandom(61050);
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      // Everything reads zero after reset, a hole too
      for (f = 0; f < 2; f++) begin
         foreach (ofs[i]) rd(f, ofs[i], 32'h0);
      end
      // Frames hold separate selectors
      d = $urandom;
      wr(0, OFS_MONITOR_SELECTOR, d);
      wr(1, OFS_MONITOR_SELECTOR, ~d);
      rd(0, OFS_MONITOR_SELECTOR, d & SELECTOR_WMASK);
      rd(1, OFS_MONITOR_SELECTOR, ~d & SELECTOR_WMASK);
      // Random monitors: scale, write, count, capture, count on
      repeat (12) begin
         f = $urandom % 2;
         m = $urandom % 8;
         @(posedge mclk_i);
         scale_en_i[f] <= 1'($urandom);
         shift_amount_i <= 5'($urandom % 7);
         pick(f, m / 4, m % 4);
         cwr(f, m, $urandom);
         rd(f, OFS_BW_COUNTER, cval(f, m));
         beats(f, m, 1 + $urandom % 6);
         beats(1 - f, m, 2);
         rd(f, OFS_BW_COUNTER, cval(f, m));
         cap(f, m);
         beats(f, m, 3);
         rd(f, OFS_BW_SNAPSHOT, snap[f][m]);
         rd(f, OFS_BW_COUNTER, cval(f, m));
      end
      // Selection just past the last bandwidth monitor
      pick(0, 0, 4);
      rd(0, OFS_BW_COUNTER, 32'h0);
      rd(0, OFS_BW_SNAPSHOT, 32'h0);
      // Not-ready forcing covers the frame; software may clear it
      pick(1, 1, 2);
      @(posedge mclk_i);
      not_ready_set_i <= 2'b10;
      @(posedge mclk_i);
      not_ready_set_i <= 2'b00;
      for (k = 0; k < 8; k++) not_ready_flag[1][k] = 1'b1;
      rd(1, OFS_BW_COUNTER, cval(1, 6));
      cwr(1, 6, 32'h0000_0005);
      rd(1, OFS_BW_COUNTER, cval(1, 6));
      d = $urandom;
      wr(1, OFS_BW_SNAPSHOT, d);
      rd(1, OFS_BW_SNAPSHOT, d);
      // Pending flags by groups of 32, end of range included
      repeat (16) csu(1'b1, $urandom % 2, $urandom % 80);
      csu(1'b1, 1, 79);
      for (k = 0; k < 4; k++) begin
         f = k % 2;
         m = (k / 2) * 32 + $urandom % 32;
         pick(f, 1, m);
         rd(f, OFS_OVERFLOW_BITMAP, bm(f, 1, m));
         wr(f, OFS_OVERFLOW_BITMAP, 32'hffff_ffff);
         rd(f, OFS_OVERFLOW_BITMAP, bm(f, 1, m));
      end
      pick(0, 0, 7);
      rd(0, OFS_OVERFLOW_BITMAP, bm(0, 0, 7));
      // Upper group of resource 0 must not show resource 1's flags
      csu(1'b1, 0, 41);
      pick(0, 0, 45);
      rd(0, OFS_OVERFLOW_BITMAP, bm(0, 0, 45));
      pick(1, 1, 39);
      rd(1, OFS_OVERFLOW_BITMAP, bm(1, 1, 39));
      csu(1'b0, 1, 79);
      rd(1, OFS_OVERFLOW_BITMAP, bm(1, 1, 39));
      results();
   end
endmodule
